// *** core/nov_stage_bank.sv ***
// neutral overvoltage protection: four stages behind an AXI4-Lite slave
// assumes RMS phase magnitudes in centivolts, synchronous to i_clock

// How it works
// - four independent stages, each with own threshold, timing and outputs
// - three phase-to-earth magnitudes are taken continuously
// - zero sequence voltage is one third of the three phase sum
// - 57.74 V zero sequence equals 100 percent nominal, line-to-line 100 V
// - all compared magnitudes are RMS values, not samples
// - blocking and setting group may change while running, effective at once
// - eight parameter sets, one active, chosen by one common selector
// - instant mode, or delayed mode as fixed time or inverse time
// - inverse time offers two standard curve families and user parameters
// - order: select, process, compare, block check, delay, output
// - start, trip and blocked outputs for I/O and user logic
// - each edge of each output makes a stamped ON or OFF event
// - instant mode gives start and trip events with equal stamps
// - event stamps have one millisecond resolution
// - cumulative counters count every start, trip and blocked
// - pick-up when magnitude exceeds active group threshold
// - release only below 97 percent of the threshold
// - start only while unblocked, otherwise blocked is raised
// - no residual channel selected falls back to calculated value
module nov_stage_bank #(
  parameter int TICK_CYCLES = nov_pkg::TICK_CYCLES_DEF
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [15:0] i_phase_a_voltage,
  input wire logic [15:0] i_phase_b_voltage,
  input wire logic [15:0] i_phase_c_voltage,
  input wire logic [15:0] i_residual_voltage,
  input wire logic i_residual_present,
  input wire logic [3:0] i_block,
  input wire logic [2:0] i_group_sel,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output nov_pkg::stage_out_t o_stage_out [4],
  output nov_pkg::stage_event_t o_event [4]
);
  import nov_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic cfg_hit(input logic [11:0] a);
    return a[11:10] == 2'h0 && a[4] == 1'b0 && a[1:0] == 2'h0;
  endfunction : cfg_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  logic [16:0] tick_cnt_reg;
  logic tick;
  logic [31:0] time_reg;

  assign tick = tick_cnt_reg == 17'(TICK_CYCLES - 1);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 17'h0;
    end else begin
      tick_cnt_reg <= tick ? 17'h0 : tick_cnt_reg + 17'h1;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      time_reg <= 32'h0;
    end else if (tick) begin
      time_reg <= time_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // registers and setting groups
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] block_reg;
  logic [31:0] event_en_reg;
  logic clear_reg;
  logic [31:0] thr_mem [32];
  logic [31:0] delay_mem [32];
  logic [31:0] dial_mem [32];
  logic [31:0] mode_mem [32];
  logic [2:0] group;
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic write_fire;
  logic write_ok;
  logic [4:0] widx;

  assign group = ctrl_reg[CTRL_GROUP_PIN] ? i_group_sel
                 : ctrl_reg[CTRL_GROUP_LSB +: 3];
  assign write_fire = aw_held_reg & w_held_reg;
  assign widx = aw_addr_reg[9:5];
  always_comb begin
    if (cfg_hit(aw_addr_reg)) begin
      write_ok = 1'b1;
    end else if (aw_addr_reg == REG_CTRL || aw_addr_reg == REG_BLOCK) begin
      write_ok = 1'b1;
    end else if (aw_addr_reg == REG_EVENT_EN) begin
      write_ok = 1'b1;
    end else begin
      write_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign o_awready = ~aw_held_reg & ~o_bvalid;
  assign o_wready = ~w_held_reg & ~o_bvalid;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= AXI_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (write_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= write_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // global control; the clear bit self-clears after one cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= CTRL_RESET;
      block_reg <= 32'h0;
      event_en_reg <= EVENT_EN_RESET;
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= 1'b0;
      if (write_fire && aw_addr_reg == REG_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_003f;
        clear_reg <= w_strb_reg[1] & w_data_reg[CTRL_CLEAR];
      end else if (write_fire && aw_addr_reg == REG_BLOCK) begin
        block_reg <= merge(block_reg, w_data_reg, w_strb_reg) & 32'h0000_000f;
      end else if (write_fire && aw_addr_reg == REG_EVENT_EN) begin
        event_en_reg <= merge(event_en_reg, w_data_reg, w_strb_reg) & 32'h0000_0003;
      end
    end
  end

  // per stage, per group settings; live writes take effect at once
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) begin
        thr_mem[i] <= THRESHOLD_RESET;
        delay_mem[i] <= DELAY_RESET;
        dial_mem[i] <= DIAL_RESET;
        mode_mem[i] <= MODE_RESET;
      end
    end else if (write_fire && cfg_hit(aw_addr_reg)) begin
      case (aw_addr_reg[3:2])
        FLD_THRESHOLD: thr_mem[widx] <= merge(thr_mem[widx], w_data_reg, w_strb_reg);
        FLD_DELAY: delay_mem[widx] <= merge(delay_mem[widx], w_data_reg, w_strb_reg);
        FLD_DIAL: dial_mem[widx] <= merge(dial_mem[widx], w_data_reg, w_strb_reg);
        default: mode_mem[widx] <= merge(mode_mem[widx], w_data_reg, w_strb_reg);
      endcase
    end
  end

  // ----------------------------------------
  // measured magnitude selection and processing
  // ----------------------------------------
  logic [17:0] phase_sum;
  logic [33:0] third_prod;
  logic [15:0] u0_reg;
  logic [33:0] pct_prod;
  logic use_residual;

  assign phase_sum = {2'b00, i_phase_a_voltage} + {2'b00, i_phase_b_voltage}
                   + {2'b00, i_phase_c_voltage};
  assign third_prod = phase_sum * THIRD_MULT;
  assign use_residual = ctrl_reg[CTRL_INPUT_LSB +: 2] == INPUT_RESIDUAL
                      & i_residual_present;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      u0_reg <= 16'h0000;
    end else begin
      u0_reg <= use_residual ? i_residual_voltage : third_prod[31:16];
    end
  end
  assign pct_prod = u0_reg * PCT_RECIP;

  // ----------------------------------------
  // stages, events and counters
  // ----------------------------------------
  stage_out_t prev_reg [4];
  logic [31:0] count_reg [12];

  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    stage_cfg_t cfg;
    logic [4:0] idx;
    logic [2:0] now;
    logic [2:0] was;
    logic [2:0] rise;
    logic [2:0] fall;

    assign idx = {2'(s), group};
    assign cfg.threshold = thr_mem[idx][15:0];
    assign cfg.delay_ms = delay_mem[idx][20:0];
    assign cfg.dial = dial_mem[idx][15:0];
    assign cfg.mode = mode_mem[idx][MODE_LSB +: 2];
    assign cfg.curve = mode_mem[idx][CURVE_LSB +: 2];
    assign cfg.gain = mode_mem[idx][GAIN_LSB +: 8];

    nov_stage_timer u_stage (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_clear(clear_reg),
      .i_tick(tick),
      .i_u0(u0_reg),
      .i_cfg(cfg),
      .i_block(i_block[s] | block_reg[s]),
      .o_out(o_stage_out[s])
    );

    assign now = o_stage_out[s];
    assign was = prev_reg[s];
    assign rise = now & ~was;
    assign fall = was & ~now;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        prev_reg[s] <= '0;
        o_event[s] <= '0;
      end else begin
        prev_reg[s] <= o_stage_out[s];
        o_event[s].changed <= (rise & {3{event_en_reg[0]}})
                            | (fall & {3{event_en_reg[1]}});
        o_event[s].level <= now;
        o_event[s].stamp <= time_reg;
      end
    end

    for (genvar k = 0; k < 3; k++) begin : g_count
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          count_reg[s*3 + k] <= 32'h0;
        end else if (rise[2 - k]) begin
          count_reg[s*3 + k] <= count_reg[s*3 + k] + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;
  logic [4:0] ridx;
  logic [11:0] status_word;
  logic [3:0] cnt_idx;

  assign ridx = i_araddr[9:5];
  assign cnt_idx = 4'(i_araddr[5:4] * 3) + {2'b00, i_araddr[3:2]};
  always_comb begin
    status_word = '0;
    for (int i = 0; i < NUM_STAGES; i++) begin
      status_word[i*3 +: 3] = o_stage_out[i];
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (cfg_hit(i_araddr)) begin
      case (i_araddr[3:2])
        FLD_THRESHOLD: rd_word = thr_mem[ridx];
        FLD_DELAY: rd_word = delay_mem[ridx];
        FLD_DIAL: rd_word = dial_mem[ridx];
        default: rd_word = mode_mem[ridx];
      endcase
    end else if (i_araddr == REG_CTRL) begin
      rd_word = ctrl_reg;
    end else if (i_araddr == REG_BLOCK) begin
      rd_word = block_reg;
    end else if (i_araddr == REG_EVENT_EN) begin
      rd_word = event_en_reg;
    end else if (i_araddr == REG_STATUS) begin
      rd_word = {13'h0, use_residual, group, 3'h0, status_word};
    end else if (i_araddr == REG_U0) begin
      rd_word = {16'h0, u0_reg};
    end else if (i_araddr == REG_U0_PCT) begin
      rd_word = {14'h0, pct_prod[33:16]};
    end else if (i_araddr == REG_TIME) begin
      rd_word = time_reg;
    end else if (i_araddr[11:6] == REG_COUNT_BASE[11:6] && i_araddr[3:2] != 2'h3
                 && i_araddr[1:0] == 2'h0) begin
      rd_word = count_reg[cnt_idx];
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign o_arready = ~o_rvalid;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= AXI_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule : nov_stage_bank

// *** core/nov_pkg.sv ***
// neutral overvoltage stage bank: shared constants, map and types
// assumes a 100 MHz clock and RMS magnitudes in centivolts
package nov_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int NUM_STAGES = 4;
  localparam int NUM_GROUPS = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // scaling: 57.74 V of zero sequence is 100 % nominal
  // ----------------------------------------
  localparam logic [15:0] U0_FULL_SCALE = 16'h168e;
  localparam logic [17:0] PCT_RECIP = 18'h1bb5e;
  localparam logic [15:0] THIRD_MULT = 16'h5556;
  localparam logic [15:0] HYST_MULT = 16'h7c29;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [1:0] FLD_THRESHOLD = 2'h0;
  localparam logic [1:0] FLD_DELAY = 2'h1;
  localparam logic [1:0] FLD_DIAL = 2'h2;
  localparam logic [1:0] FLD_MODE = 2'h3;
  localparam logic [11:0] REG_CTRL = 12'h400;
  localparam logic [11:0] REG_BLOCK = 12'h404;
  localparam logic [11:0] REG_EVENT_EN = 12'h408;
  localparam logic [11:0] REG_STATUS = 12'h40c;
  localparam logic [11:0] REG_U0 = 12'h410;
  localparam logic [11:0] REG_U0_PCT = 12'h414;
  localparam logic [11:0] REG_TIME = 12'h418;
  localparam logic [11:0] REG_COUNT_BASE = 12'h500;
  localparam int CTRL_GROUP_LSB = 0;
  localparam int CTRL_GROUP_PIN = 3;
  localparam int CTRL_INPUT_LSB = 4;
  localparam int CTRL_CLEAR = 8;
  localparam int MODE_LSB = 0;
  localparam int CURVE_LSB = 2;
  localparam int GAIN_LSB = 8;
  localparam logic [1:0] INPUT_NONE = 2'h0;
  localparam logic [1:0] INPUT_CALC = 2'h1;
  localparam logic [1:0] INPUT_RESIDUAL = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_EN_RESET = 32'h0000_0003;
  localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0483;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0028;
  localparam logic [31:0] DIAL_RESET = 32'h0000_0032;
  localparam logic [31:0] MODE_RESET = 32'h0000_1001;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DLY_INSTANT = 2'h0, DLY_FIXED = 2'h1, DLY_INVERSE = 2'h2
  } delay_mode_t;
  typedef struct packed {
    logic [15:0] threshold;
    logic [20:0] delay_ms;
    logic [15:0] dial;
    logic [1:0] mode;
    logic [1:0] curve;
    logic [7:0] gain;
  } stage_cfg_t;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } stage_out_t;
  typedef struct packed {
    logic [2:0] changed;
    logic [2:0] level;
    logic [31:0] stamp;
  } stage_event_t;

endpackage : nov_pkg

// *** core/nov_stage_timer.sv ***
// one neutral overvoltage stage: pick-up, block check, delay, outputs
// assumes i_tick is a one-cycle pulse every millisecond
module nov_stage_timer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [15:0] i_u0,
  input nov_pkg::stage_cfg_t i_cfg,
  input wire logic i_block,
  output nov_pkg::stage_out_t o_out
);
  import nov_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_TIMING = 3'b010, ST_TRIPPED = 3'b100
  } state_t;

  state_t state_reg;
  logic picked_reg;
  logic picked_next;
  logic start_next;
  logic trip_next;
  logic done;
  logic [31:0] hyst_prod;
  logic [15:0] excess;
  logic [31:0] sq;
  logic [23:0] scaled;
  logic [39:0] step;
  logic [39:0] acc_reg;
  logic [20:0] elapsed_reg;
  logic [31:0] limit;

  // ----------------------------------------
  // comparator with fixed 97 % release
  // ----------------------------------------
  assign hyst_prod = i_cfg.threshold * HYST_MULT;
  always_comb begin
    picked_next = picked_reg;
    if (i_u0 > i_cfg.threshold) begin
      picked_next = 1'b1;
    end else if (i_u0 < hyst_prod[30:15]) begin
      picked_next = 1'b0;
    end
  end
  assign start_next = picked_next & ~i_block;

  // ----------------------------------------
  // delay characteristic
  // ----------------------------------------
  assign excess = (i_u0 > i_cfg.threshold) ? i_u0 - i_cfg.threshold : 16'h0000;
  assign sq = excess * excess;
  assign scaled = excess * i_cfg.gain;
  always_comb begin
    case (i_cfg.curve)
      2'h0: step = {24'h000000, excess};
      2'h1: step = {16'h0000, sq[31:8]};
      default: step = {20'h00000, scaled[23:4]};
    endcase
  end
  assign limit = i_cfg.dial * i_cfg.threshold;
  always_comb begin
    case (i_cfg.mode)
      DLY_FIXED: done = (i_cfg.delay_ms == 21'h0) | (elapsed_reg >= i_cfg.delay_ms);
      DLY_INVERSE: done = acc_reg >= {8'h00, limit};
      default: done = 1'b1;
    endcase
  end
  assign trip_next = start_next & (done | state_reg == ST_TRIPPED);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      picked_reg <= 1'b0;
      o_out <= '0;
    end else if (i_clear) begin
      picked_reg <= 1'b0;
      o_out <= '0;
    end else begin
      picked_reg <= picked_next;
      o_out.start <= start_next;
      o_out.trip <= trip_next;
      o_out.blocked <= picked_next & i_block;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      elapsed_reg <= 21'h0;
      acc_reg <= 40'h0;
    end else if (i_clear || !start_next) begin
      state_reg <= ST_IDLE;
      elapsed_reg <= 21'h0;
      acc_reg <= 40'h0;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= trip_next ? ST_TRIPPED : ST_TIMING;
        ST_TIMING: state_reg <= trip_next ? ST_TRIPPED : ST_TIMING;
        default: state_reg <= ST_TRIPPED;
      endcase
      if (i_tick && state_reg == ST_TIMING) begin
        elapsed_reg <= elapsed_reg + 21'h1;
        acc_reg <= acc_reg + step;
      end
    end
  end

endmodule : nov_stage_timer

// *** bench/nov_stage_bank_monitor.sv ***
// checker: stage 0 outputs against its events and its block input
// assumes it is bound into nov_stage_bank and sees only that module's ports
module nov_stage_bank_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_block,
  input nov_pkg::stage_out_t o_stage_out [4],
  input nov_pkg::stage_event_t o_event [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  import nov_pkg::*;
  stage_out_t out0;
  stage_event_t ev0;
  assign out0 = o_stage_out[0];
  assign ev0 = o_event[0];
  default clocking mon_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_block_held;
    i_block[0] [*4];
  endsequence
  sequence s_instant_rise;
    $rose(out0.start) && out0.trip;
  endsequence
  AST_TRIP_NEEDS_START: assert property (out0.trip |-> out0.start)
    else $error("trip high without start");
  AST_START_NOT_BLOCKED: assert property (!(out0.start && out0.blocked))
    else $error("start and blocked together");
  AST_BLOCK_HOLDS_OFF: assert property (s_block_held |-> !out0.start)
    else $error("start while blocked");
  AST_TRIP_AFTER_START: assert property (
    $rose(out0.trip) && !$rose(out0.start) |-> $past(out0.start))
    else $error("delayed trip without start before it");
  AST_INSTANT_PAIR: assert property (s_instant_rise |=> ev0.changed[2:1] == 2'b11)
    else $error("instant start and trip not in one event");
  AST_EVENT_PRESENT: assert property (out0 != $past(out0) |=> ev0.changed != 3'h0)
    else $error("output edge without event");
  AST_EVENT_EDGES: assert property (
    ev0.changed != 3'h0 |-> ev0.changed == ($past(out0) ^ $past(out0, 2)))
    else $error("event changed bits wrong");
  AST_EVENT_LEVEL: assert property (ev0.changed != 3'h0 |-> ev0.level == $past(out0))
    else $error("event level wrong");
endmodule : nov_stage_bank_monitor

bind nov_stage_bank nov_stage_bank_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_block(i_block),
  .o_stage_out(o_stage_out), .o_event(o_event)
);

// *** bench/nov_front_end.sv ***
// model of the measurement front end: RMS phase and residual magnitudes
// assumes the bench asks for a zero sequence level; slow mode ramps up to it, a lower level is taken at once
module nov_front_end (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic [15:0] i_level,
  input wire logic [15:0] i_residual,
  output logic [15:0] o_phase_a_voltage,
  output logic [15:0] o_phase_b_voltage,
  output logic [15:0] o_phase_c_voltage,
  output logic [15:0] o_residual_voltage,
  output logic o_residual_present
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] now_reg;
  logic [15:0] skew;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) now_reg <= 16'h0000;
    else if (!i_slow || now_reg + 16'h0010 > i_level) now_reg <= i_level;
    else now_reg <= now_reg + 16'h0010;
  end
  // unequal phases whose mean is the level, so the sum path is exercised
  assign skew = (now_reg > 16'h0064) ? 16'h0064 : 16'h0000;
  assign o_phase_a_voltage = now_reg;
  assign o_phase_b_voltage = now_reg + skew;
  assign o_phase_c_voltage = now_reg - skew;
  assign o_residual_voltage = i_residual;
  assign o_residual_present = 1'b1;
endmodule : nov_front_end

// *** bench/neutral_overvoltage_stage_bench.sv ***
// self-checking bench for the neutral overvoltage stage bank
// assumes the front-end model feeds the phases and a 10-cycle ms tick
module neutral_overvoltage_stage_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import nov_pkg::*;
  typedef struct packed {logic [15:0] lvl; logic b; logic [2:0] o;} row_t;
  localparam row_t ROWS [8] = '{'{16'h03e8, 1'b0, 3'h0}, '{16'h0483, 1'b0, 3'h0},
    '{16'h0484, 1'b0, 3'h6}, '{16'h046a, 1'b0, 3'h6}, '{16'h044c, 1'b0, 3'h0},
    '{16'h04b0, 1'b1, 3'h1}, '{16'h04b0, 1'b0, 3'h6}, '{16'h0000, 1'b0, 3'h0}};
  logic clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, slow, aw_r, w_r, b_v, ar_r, r_v, res_p;
  logic [1:0] b_resp, r_resp;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [15:0] va, vb, vc, vres, level, resid;
  logic [3:0] blk;
  logic [2:0] grp;
  stage_out_t outs [4];
  stage_event_t evs [4];
  int n_errors = 0;
  int checks_done = 0;
  int t;
  nov_front_end u_front (.i_clock(clk), .i_rst_n(rst_n), .i_slow(slow), .i_level(level),
    .i_residual(resid), .o_phase_a_voltage(va), .o_phase_b_voltage(vb),
    .o_phase_c_voltage(vc), .o_residual_voltage(vres), .o_residual_present(res_p));
  nov_stage_bank #(.TICK_CYCLES(10)) u_dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_phase_a_voltage(va), .i_phase_b_voltage(vb), .i_phase_c_voltage(vc),
    .i_residual_voltage(vres), .i_residual_present(res_p), .i_block(blk),
    .i_group_sel(grp), .i_awvalid(aw_v), .o_awready(aw_r), .i_awaddr(aw_a),
    .i_wvalid(w_v), .o_wready(w_r), .i_wdata(w_d), .i_wstrb(4'hf), .o_bvalid(b_v),
    .i_bready(b_r), .o_bresp(b_resp), .i_arvalid(ar_v), .o_arready(ar_r),
    .i_araddr(ar_a), .o_rvalid(r_v), .i_rready(r_r), .o_rdata(r_d), .o_rresp(r_resp),
    .o_stage_out(outs), .o_event(evs));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // ready stays high after the answer, so back-to-back calls never drive it twice at one edge;
  // only the watchdog ends a wait for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    check("bresp", {30'h0, er}, {30'h0, b_resp});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    check("rresp", {30'h0, er}, {30'h0, r_resp});
    check("rdata", ed, r_d);
  endtask : rd
  task automatic settle(input logic [15:0] lv);
    level <= lv;
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, aw_v, w_v, b_r, ar_v, r_r, slow, blk, grp} = '0;
    {aw_a, ar_a, w_d, level, resid} = '0;
    repeat (12) @(posedge clk);
    check("reset_out", 32'h0, {29'h0, outs[0]});
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'h000, THRESHOLD_RESET, AXI_OKAY);
    rd(12'h004, DELAY_RESET, AXI_OKAY);
    rd(12'h008, DIAL_RESET, AXI_OKAY);
    rd(12'h10c, MODE_RESET, AXI_OKAY);
    rd(REG_EVENT_EN, EVENT_EN_RESET, AXI_OKAY);
    rd(12'h7f0, 32'h0, AXI_SLVERR);
    wr(REG_COUNT_BASE, 32'h1, AXI_SLVERR);
    wr(12'h00c, 32'h1000, AXI_OKAY);
    foreach (ROWS[i]) begin
      blk <= {3'h0, ROWS[i].b};
      settle(ROWS[i].lvl);
      check("out0", {29'h0, ROWS[i].o}, {29'h0, outs[0]});
      rd(REG_U0, {16'h0, ROWS[i].lvl}, AXI_OKAY);
    end
    rd(REG_COUNT_BASE, 32'h2, AXI_OKAY);
    rd(REG_COUNT_BASE + 12'h004, 32'h2, AXI_OKAY);
    rd(REG_COUNT_BASE + 12'h008, 32'h1, AXI_OKAY);
    wr(REG_CTRL, 32'h100, AXI_OKAY);
    rd(REG_COUNT_BASE, 32'h2, AXI_OKAY);
    wr(12'h060, 32'h7d0, AXI_OKAY);
    wr(12'h06c, 32'h1000, AXI_OKAY);
    wr(REG_CTRL, 32'h8, AXI_OKAY);
    grp <= 3'h3;
    settle(16'h05dc);
    check("group3_out", 32'h0, {29'h0, outs[0]});
    grp <= 3'h0;
    repeat (8) @(posedge clk);
    check("group0_out", 32'h6, {29'h0, outs[0]});
    rd(REG_U0_PCT, 32'(32'h5dc * 32'h2710 / U0_FULL_SCALE), AXI_OKAY);
    rd(REG_STATUS, 32'h0000_0926, AXI_OKAY);
    settle(16'h0000);
    level <= 16'h04b0;
    t = 0;
    while (evs[0].changed === 3'h0 && t < 20) begin
      @(posedge clk);
      t++;
    end
    check("ev_changed", 32'h6, {29'h0, evs[0].changed});
    check("ev_level", 32'h6, {29'h0, evs[0].level});
    settle(16'h0000);
    wr(12'h004, 32'h3, AXI_OKAY);
    wr(12'h00c, 32'h1001, AXI_OKAY);
    level <= 16'h04b0;
    t = 0;
    while (outs[0].start !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    t = 0;
    while (outs[0].trip !== 1'b1 && t < 60) begin
      @(posedge clk);
      t++;
    end
    check("fixed_delay", 32'h1, {31'h0, t >= 20 && t <= 32});
    settle(16'h0000);
    check("fixed_clear", 32'h0, {29'h0, outs[0]});
    wr(REG_CTRL, 32'h20, AXI_OKAY);
    resid <= 16'h0309;
    repeat (4) @(posedge clk);
    rd(REG_U0, 32'h309, AXI_OKAY);
    wr(REG_CTRL, 32'h0, AXI_OKAY);
    rd(REG_U0, 32'h0, AXI_OKAY);
    slow <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(12'h00c, 32'h1002 | (c << 2), AXI_OKAY);
      level <= 16'h0bb8;
      t = 0;
      while (outs[0].trip !== 1'b1 && t < 1000) begin
        @(posedge clk);
        t++;
      end
      check("inverse_trip", 32'h1, {31'h0, outs[0].trip});
      settle(16'h0000);
    end
    print_verdict();
  end
endmodule : neutral_overvoltage_stage_bench
